// >>> inc/fls_pkg.sv
// Constants, types and operation codes for the flag and load/store unit.
// Operation
// RL1 - overflow set forces one, clear forces zero
// RL2 - half carry set writes one, one cycle
// RL3 - half carry clear writes zero, one cycle
// RL4 - sign test set writes one, one cycle
// RL5 - sign test clear writes zero, one cycle
// RL6 - transfer bit set and clear, one cycle
// RL7 - irq off clears, irq on sets enable
// RL8 - zero flag clear and set, one cycle
// RL9 - register copy, one cycle, flags untouched
// RL10 - pair copy high/low, one cycle, flags untouched
// RL11 - immediate load into destination, one cycle
// RL12 - first pointer load, two cycles, no flags
// RL13 - first pointer post-increment load, two cycles
// RL14 - first pointer pre-decrement then load
// RL15 - second pointer plain, increment, decrement loads
// RL16 - second pointer plus offset, pointer kept
// RL17 - third pointer all four load forms
// RL18 - direct address load, two cycles
// RL19 - first pointer store, two cycles, no flags
// RL20 - post-increment store writes then increments
// RL21 - pre-decrement store decrements then writes
// RL22 - negative flag set and clear, one cycle
// RL23 - pointer steps carry across bytes, wrap
package fls_pkg;

    // ==========================================================
    // Register map (byte addresses) and reset values.
    localparam logic [7:0]  OFS_INSTR = 8'h00;
    localparam logic [7:0]  OFS_DADDR = 8'h04;
    localparam logic [7:0]  OFS_STAT  = 8'h08;
    localparam logic [7:0]  OFS_STATUS_REGISTER  = 8'h0C;
    localparam logic [7:0]  OFS_GPR   = 8'h80;
    localparam logic [31:0] INSTR_RST = 32'h0000_0000;
    localparam logic [15:0] DADDR_RST = 16'h0000;
    localparam logic [7:0]  STATUS_REGISTER_RST  = 8'h00;
    localparam logic [7:0]  GPR_RST   = 8'h00;
    localparam int          STAT_BUSY = 0;
    localparam int          STAT_BAD  = 1;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLV  = 2'h2;

    // ==========================================================
    // Status register bit positions.
    localparam logic [2:0] BIT_C = 3'h0;
    localparam logic [2:0] BIT_Z = 3'h1;
    localparam logic [2:0] BIT_N = 3'h2;
    localparam logic [2:0] BIT_V = 3'h3;
    localparam logic [2:0] BIT_S = 3'h4;
    localparam logic [2:0] BIT_H = 3'h5;
    localparam logic [2:0] BIT_T = 3'h6;
    localparam logic [2:0] BIT_I = 3'h7;

    // ==========================================================
    // Pointer selection and addressing modes.
    localparam logic [1:0] SEL_DIR    = 2'h0;
    localparam logic [1:0] SEL_X      = 2'h1;
    localparam logic [1:0] SEL_Y      = 2'h2;
    localparam logic [1:0] SEL_Z      = 2'h3;
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_INC   = 2'h1;
    localparam logic [1:0] MODE_DEC   = 2'h2;
    localparam logic [1:0] MODE_DISP  = 2'h3;

    // ==========================================================
    // Operation codes held in the low field of the command word.
    typedef enum logic [5:0] {
        OP_NOP         = 6'h00,
        OP_IRQ_ON      = 6'h01,
        OP_IRQ_OFF     = 6'h02,
        OP_T_SET       = 6'h03,
        OP_T_CLR       = 6'h04,
        OP_H_SET       = 6'h05,
        OP_H_CLR       = 6'h06,
        OP_S_SET       = 6'h07,
        OP_S_CLR       = 6'h08,
        OP_V_SET       = 6'h09,
        OP_V_CLR       = 6'h0A,
        OP_N_SET       = 6'h0B,
        OP_N_CLR       = 6'h0C,
        OP_Z_SET       = 6'h0D,
        OP_Z_CLR       = 6'h0E,
        OP_REG_COPY    = 6'h10,
        OP_PAIR_COPY   = 6'h11,
        OP_IMM_LOAD    = 6'h12,
        OP_LD_X        = 6'h13,
        OP_LD_X_INC    = 6'h14,
        OP_LD_X_DEC    = 6'h15,
        OP_LD_Y        = 6'h16,
        OP_LD_Y_INC    = 6'h17,
        OP_LD_Y_DEC    = 6'h18,
        OP_LD_Y_DISP   = 6'h19,
        OP_LD_Z        = 6'h1A,
        OP_LD_Z_INC    = 6'h1B,
        OP_LD_Z_DEC    = 6'h1C,
        OP_LD_Z_DISP   = 6'h1D,
        OP_DIRECT_LOAD = 6'h1E,
        OP_ST_X        = 6'h1F,
        OP_ST_X_INC    = 6'h20,
        OP_ST_X_DEC    = 6'h21
    } fls_op_t;

    // Command word: immediate or offset, source, destination, op.
    typedef struct packed {
        logic [7:0] imm;
        logic [2:0] rsv2;
        logic [4:0] src;
        logic [2:0] rsv1;
        logic [4:0] dst;
        logic [1:0] rsv0;
        logic [5:0] op;
    } fls_instr_t;

    // Data memory request, one byte per access.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } fls_mem_req_t;

    typedef struct packed {
        logic       hit;
        logic [2:0] idx;
        logic       val;
    } fls_flag_dec_t;

    typedef struct packed {
        logic       is_mem;
        logic       store;
        logic [1:0] sel;
        logic [1:0] mode;
    } fls_mem_dec_t;

endpackage

// >>> hw/fls_exec.sv
`timescale 1ns/1ps
// Flag, move and load/store execution unit with an AXI4-Lite register slave.
module fls_exec (
    input  wire logic                  ref_clk_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  s_axi_awvalid_in,
    output      logic                  s_axi_awready_out,
    input  wire logic [7:0]            s_axi_awaddr_in,
    input  wire logic                  s_axi_wvalid_in,
    output      logic                  s_axi_wready_out,
    input  wire logic [31:0]           s_axi_wdata_in,
    input  wire logic [3:0]            s_axi_wstrb_in,
    output      logic                  s_axi_bvalid_out,
    input  wire logic                  s_axi_bready_in,
    output      logic [1:0]            s_axi_bresp_out,
    input  wire logic                  s_axi_arvalid_in,
    output      logic                  s_axi_arready_out,
    input  wire logic [7:0]            s_axi_araddr_in,
    output      logic                  s_axi_rvalid_out,
    input  wire logic                  s_axi_rready_in,
    output      logic [31:0]           s_axi_rdata_out,
    output      logic [1:0]            s_axi_rresp_out,
    output      fls_pkg::fls_mem_req_t mem_req_out,
    input  wire logic [7:0]            mem_rdata_in
);
    import fls_pkg::*;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_MEM  = 1'b1
    } fls_state_t;

    logic          rst_meta;
    logic          sync_reset_n;
    fls_state_t    state;
    logic          pending;
    logic          bad_op;
    fls_instr_t    cmd;
    logic [15:0]   daddr;
    logic [7:0]    status_register;
    logic [7:0]    gpr [32];
    logic          aw_hold;
    logic          w_hold;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          busy;
    logic          exec_go;
    logic          wr_commit;
    logic          wr_ok;
    fls_op_t       op;
    fls_flag_dec_t fl;
    fls_mem_dec_t  md;
    logic [4:0]    ptr_lo;
    logic [4:0]    ptr_hi;
    logic [15:0]   ptr;
    logic [15:0]   ea;
    logic [15:0]   new_ptr;
    logic          known;
    logic [7:0]    src_val;

    // ==========================================================
    // Helper functions.

    // Merges the byte lanes enabled by the strobes into a word.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // True for an aligned address that names a register.
    function automatic logic reg_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a[7] || a == OFS_INSTR ||
               a == OFS_DADDR || a == OFS_STAT || a == OFS_STATUS_REGISTER);
    endfunction

    // Read value of the register at an address, zero if unmapped below 0x80.
    function automatic logic [31:0] rd_val(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a[7]) begin
            r[7:0] = gpr[a[6:2]];
        end else if (a == OFS_INSTR) begin
            r = cmd;
        end else if (a == OFS_DADDR) begin
            r[15:0] = daddr;
        end else if (a == OFS_STAT) begin
            r[STAT_BUSY] = busy;
            r[STAT_BAD] = bad_op;
        end else if (a == OFS_STATUS_REGISTER) begin
            r[7:0] = status_register;
        end
        return r;
    endfunction

    // Maps a flag operation to its status bit and new value.
    function automatic fls_flag_dec_t flag_dec(input fls_op_t o);
        fls_flag_dec_t d;
        d = '{hit: 1'h1, idx: BIT_I, val: 1'h1};
        unique case (o)
            OP_IRQ_ON:  d.idx = BIT_I;
            OP_IRQ_OFF: d = '{1'h1, BIT_I, 1'h0};
            OP_T_SET:   d.idx = BIT_T;
            OP_T_CLR:   d = '{1'h1, BIT_T, 1'h0};
            OP_H_SET:   d.idx = BIT_H;
            OP_H_CLR:   d = '{1'h1, BIT_H, 1'h0};
            OP_S_SET:   d.idx = BIT_S;
            OP_S_CLR:   d = '{1'h1, BIT_S, 1'h0};
            OP_V_SET:   d.idx = BIT_V;
            OP_V_CLR:   d = '{1'h1, BIT_V, 1'h0};
            OP_N_SET:   d.idx = BIT_N;
            OP_N_CLR:   d = '{1'h1, BIT_N, 1'h0};
            OP_Z_SET:   d.idx = BIT_Z;
            OP_Z_CLR:   d = '{1'h1, BIT_Z, 1'h0};
            default:    d.hit = 1'h0;
        endcase
        return d;
    endfunction

    // Maps a memory operation to pointer, mode and direction.
    function automatic fls_mem_dec_t mem_dec(input fls_op_t o);
        fls_mem_dec_t d;
        d = '{1'h1, 1'h0, SEL_X, MODE_PLAIN};
        unique case (o)
            OP_LD_X:        d.mode = MODE_PLAIN;
            OP_LD_X_INC:    d.mode = MODE_INC;
            OP_LD_X_DEC:    d.mode = MODE_DEC;
            OP_LD_Y:        d.sel = SEL_Y;
            OP_LD_Y_INC:    d = '{1'h1, 1'h0, SEL_Y, MODE_INC};
            OP_LD_Y_DEC:    d = '{1'h1, 1'h0, SEL_Y, MODE_DEC};
            OP_LD_Y_DISP:   d = '{1'h1, 1'h0, SEL_Y, MODE_DISP};
            OP_LD_Z:        d.sel = SEL_Z;
            OP_LD_Z_INC:    d = '{1'h1, 1'h0, SEL_Z, MODE_INC};
            OP_LD_Z_DEC:    d = '{1'h1, 1'h0, SEL_Z, MODE_DEC};
            OP_LD_Z_DISP:   d = '{1'h1, 1'h0, SEL_Z, MODE_DISP};
            OP_DIRECT_LOAD: d.sel = SEL_DIR;
            OP_ST_X:        d.store = 1'h1;
            OP_ST_X_INC:    d = '{1'h1, 1'h1, SEL_X, MODE_INC};
            OP_ST_X_DEC:    d = '{1'h1, 1'h1, SEL_X, MODE_DEC};
            default:        d.is_mem = 1'h0;
        endcase
        return d;
    endfunction

    // ==========================================================
    // Reset release through two flip-flops.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'h0;
            sync_reset_n <= 1'h0;
        end else begin
            rst_meta <= 1'h1;
            sync_reset_n <= rst_meta;
        end
    end

    // ==========================================================
    // Command decode and effective address.

    // Pointer pair sits at 0x1A + 2*(sel-1): low byte even, high odd.
    always_comb begin
        op = fls_op_t'(cmd.op);
        fl = flag_dec(op);
        md = mem_dec(op);
        known = fl.hit || md.is_mem || op == OP_NOP ||
                op == OP_REG_COPY || op == OP_PAIR_COPY ||
                op == OP_IMM_LOAD;
        ptr_lo = {2'h3, md.sel, 1'h0};
        ptr_hi = {2'h3, md.sel, 1'h1};
        ptr = {gpr[ptr_hi], gpr[ptr_lo]};
        src_val = gpr[cmd.src];
        // Sixteen-bit steps carry between bytes and wrap. [RL23]
        unique case (md.mode)
            MODE_INC:   new_ptr = ptr + 16'h0001;
            MODE_DEC:   new_ptr = ptr - 16'h0001;
            default:    new_ptr = ptr;
        endcase
        // Pre-decrement uses the new value; displacement keeps pointer.
        if (md.sel == SEL_DIR) begin
            ea = daddr; // [RL18]
        end else if (md.mode == MODE_DEC) begin
            ea = new_ptr; // [RL14] [RL21]
        end else if (md.mode == MODE_DISP) begin
            ea = ptr + {10'h000, cmd.imm[5:0]}; // [RL16] [RL17]
        end else begin
            ea = ptr; // [RL13] [RL20]
        end
    end

    // Busy while a command waits or a memory cycle runs.
    assign busy = pending || (state == ST_MEM);
    assign exec_go = pending && (state == ST_IDLE);
    assign wr_commit = aw_hold && w_hold && !s_axi_bvalid_out;
    assign wr_ok = reg_ok(aw_addr) && aw_addr != OFS_STAT && !busy;

    // ==========================================================
    // AXI4-Lite write channels: address and data in either order.
    always_ff @(posedge ref_clk_in or negedge sync_reset_n) begin
        if (!sync_reset_n) begin
            aw_hold <= 1'h0;
            w_hold <= 1'h0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready_out <= 1'h1;
            s_axi_wready_out <= 1'h1;
            s_axi_bvalid_out <= 1'h0;
            s_axi_bresp_out <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_hold <= 1'h1;
                aw_addr <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'h0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_hold <= 1'h1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'h0;
            end
            // Busy or unmapped writes are dropped with SLVERR.
            if (wr_commit) begin
                aw_hold <= 1'h0;
                w_hold <= 1'h0;
                s_axi_bvalid_out <= 1'h1;
                s_axi_bresp_out <= wr_ok ? RESP_OKAY : RESP_SLV;
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'h0;
                s_axi_awready_out <= 1'h1;
                s_axi_wready_out <= 1'h1;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channel: answer one cycle after the address.
    always_ff @(posedge ref_clk_in or negedge sync_reset_n) begin
        if (!sync_reset_n) begin
            s_axi_arready_out <= 1'h1;
            s_axi_rvalid_out <= 1'h0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'h0;
            s_axi_rvalid_out <= 1'h1;
            s_axi_rdata_out <= rd_val(s_axi_araddr_in);
            s_axi_rresp_out <= reg_ok(s_axi_araddr_in) ? RESP_OKAY : RESP_SLV;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_arready_out <= 1'h1;
            s_axi_rvalid_out <= 1'h0;
        end
    end

    // ==========================================================
    // Command word, direct address and pending flag.
    always_ff @(posedge ref_clk_in or negedge sync_reset_n) begin
        if (!sync_reset_n) begin
            cmd <= INSTR_RST;
            daddr <= DADDR_RST;
            pending <= 1'h0;
        end else begin
            if (wr_commit && wr_ok && aw_addr == OFS_INSTR) begin
                cmd <= merge(cmd, w_data, w_strb);
                pending <= 1'h1;
            end else if (exec_go) begin
                pending <= 1'h0;
            end
            if (wr_commit && wr_ok && aw_addr == OFS_DADDR) begin
                daddr <= 16'(merge({16'h0000, daddr}, w_data, w_strb));
            end
        end
    end

    // ==========================================================
    // Sequencer: memory operations spend one extra cycle in ST_MEM.
    always_ff @(posedge ref_clk_in or negedge sync_reset_n) begin
        if (!sync_reset_n) begin
            state <= ST_IDLE;
            bad_op <= 1'h0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (exec_go && md.is_mem) begin
                        state <= ST_MEM; // [RL12] [RL15] [RL19]
                    end
                end
                ST_MEM: begin
                    state <= ST_IDLE;
                end
            endcase
            if (exec_go) begin
                bad_op <= !known;
            end
        end
    end

    // ==========================================================
    // Data memory request, held one cycle per access.
    always_ff @(posedge ref_clk_in or negedge sync_reset_n) begin
        if (!sync_reset_n) begin
            mem_req_out <= '0;
        end else begin
            mem_req_out.re <= exec_go && md.is_mem && !md.store;
            mem_req_out.we <= exec_go && md.is_mem && md.store; // [RL19]
            if (exec_go && md.is_mem) begin
                mem_req_out.addr <= ea;
                mem_req_out.wdata <= src_val;
            end
        end
    end

    // ==========================================================
    // Register file and status register.
    always_ff @(posedge ref_clk_in or negedge sync_reset_n) begin
        if (!sync_reset_n) begin
            status_register <= STATUS_REGISTER_RST;
            for (int i = 0; i < 32; i++) begin
                gpr[i] <= GPR_RST;
            end
        end else begin
            // Software writes land only while the unit is idle.
            if (wr_commit && wr_ok && w_strb[0]) begin
                if (aw_addr[7]) begin
                    gpr[aw_addr[6:2]] <= w_data[7:0];
                end else if (aw_addr == OFS_STATUS_REGISTER) begin
                    status_register <= w_data[7:0];
                end
            end
            if (exec_go) begin
                // One status bit changes, the rest hold. [RL1] [RL2] [RL3] [RL4]
                if (fl.hit) begin
                    status_register[fl.idx] <= fl.val; // [RL5] [RL6] [RL7] [RL8] [RL22]
                end
                unique case (op)
                    OP_REG_COPY: begin
                        gpr[cmd.dst] <= src_val; // [RL9]
                    end
                    OP_PAIR_COPY: begin
                        gpr[{cmd.dst[4:1], 1'h0}] <= gpr[{cmd.src[4:1], 1'h0}]; // [RL10]
                        gpr[{cmd.dst[4:1], 1'h1}] <= gpr[{cmd.src[4:1], 1'h1}];
                    end
                    OP_IMM_LOAD: begin
                        gpr[cmd.dst] <= cmd.imm; // [RL11]
                    end
                    default: begin
                    end
                endcase
                // Pointer write-back in the address cycle. [RL13] [RL14]
                if (md.is_mem && md.sel != SEL_DIR) begin
                    gpr[ptr_lo] <= new_ptr[7:0]; // [RL15] [RL17] [RL20] [RL21]
                    gpr[ptr_hi] <= new_ptr[15:8];
                end
            end
            // Load data taken in the second cycle. [RL12] [RL18]
            if (state == ST_MEM && !md.store) begin
                gpr[cmd.dst] <= mem_rdata_in;
            end
        end
    end

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!sync_reset_n);

    property p_flag(logic [5:0] o, int b, logic v);
        exec_go && cmd.op == o |=> status_register[b] == v &&
            ((status_register ^ $past(status_register)) & ~(8'h01 << b)) == 8'h00;
    endproperty

    sequence s_load_go;
        exec_go && md.is_mem && !md.store;
    endsequence

    sequence s_load_done;
        !mem_req_out.re && state == ST_IDLE;
    endsequence

    a_ovf_set_one: assert property (p_flag(OP_V_SET, 3, 1'h1)) // [RL1]
        else $error("overflow set failed");
    a_half_set: assert property (p_flag(OP_H_SET, 5, 1'h1)) // [RL2]
        else $error("half carry set failed");
    a_half_clear: assert property (p_flag(OP_H_CLR, 5, 1'h0)) // [RL3]
        else $error("half carry clear failed");
    a_sign_set: assert property (p_flag(OP_S_SET, 4, 1'h1)) // [RL4]
        else $error("sign set failed");
    a_sign_clear: assert property (p_flag(OP_S_CLR, 4, 1'h0)) // [RL5]
        else $error("sign clear failed");
    a_tbit_clear: assert property (p_flag(OP_T_CLR, 6, 1'h0)) // [RL6]
        else $error("transfer bit clear failed");
    a_irq_off: assert property (p_flag(OP_IRQ_OFF, 7, 1'h0)) // [RL7]
        else $error("irq off failed");
    a_zero_clear: assert property (p_flag(OP_Z_CLR, 1, 1'h0)) // [RL8]
        else $error("zero clear failed");
    a_neg_set: assert property (p_flag(OP_N_SET, 2, 1'h1)) // [RL22]
        else $error("negative set failed");

    a_copy_one_cycle: assert property ( // [RL9]
        exec_go && op == OP_REG_COPY |=>
            gpr[$past(cmd.dst)] == $past(src_val) && status_register == $past(status_register))
        else $error("register copy wrong");

    a_load_two_cycles: assert property ( // [RL12]
        s_load_go |=> mem_req_out.re && mem_req_out.addr == $past(ea)
            ##1 (s_load_done and (gpr[$past(cmd.dst, 2)] == $past(mem_rdata_in))))
        else $error("load sequence wrong");

    a_ptr_post_inc: assert property ( // [RL13]
        exec_go && md.is_mem && md.mode == MODE_INC |=>
            mem_req_out.addr == $past(ptr) && ptr == $past(ptr) + 16'h0001)
        else $error("post increment wrong");

    a_store_write: assert property ( // [RL19]
        exec_go && md.store |=> mem_req_out.we &&
            mem_req_out.wdata == $past(src_val) ##1 !mem_req_out.we)
        else $error("store sequence wrong");

endmodule // fls_exec

// >>> tb/tb.sv
// Self-checking bench for the flag and load/store unit.
`timescale 1ns/1ps
module tb;
    import fls_pkg::*;
    // ==========================================================
    // Stimulus signals and scoreboards.
    logic         clk = 0, rst_n = 0, awv = 0, wv = 0, br = 1, arv = 0, rr = 1;
    logic         awr, wrdy, bv, arr, rv;
    logic [7:0]   awa = 8'h00, ara = 8'h00, mrd;
    logic [31:0]  wd = 32'h0, rdat;
    logic [1:0]   bresp, rresp;
    fls_mem_req_t mq;
    logic [33:0]  exp_q[$];
    logic [33:0]  mem_q[$];
    logic [1:0]   b_q[$];
    int           mismatches = 0, comparisons = 0;
    localparam int SL[15] = '{1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 0, 1, 1, 1};
    localparam int MD[15] = '{0, 1, 2, 0, 1, 2, 3, 0, 1, 2, 3, 0, 0, 1, 2};

    fls_exec dut (.ref_clk_in(clk), .reset_n_in(rst_n), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wrdy), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rresp), .mem_req_out(mq), .mem_rdata_in(mrd));

    // Clock of 5 ns period; memory answers at once with a pattern of its address.
    always #2.5 clk = ~clk;
    function automatic logic [7:0] memf(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    assign mrd = memf(mq.addr);
    function automatic logic [7:0] gpr(input int n);
        return OFS_GPR + 8'(n * 4);
    endfunction

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Monitor takes the oldest note whenever a read answer or memory access shows.
    always @(posedge clk) begin
        if (rv && rr) chk({rresp, rdat}, exp_q.pop_front());
        if (bv && br) chk(34'(bresp), 34'(b_q.pop_front()));
        if (mq.we || mq.re) chk({8'h0, mq.addr, mq.we ? mq.wdata : 8'h00, mq.we, mq.re},
            mem_q.pop_front());
    end

    // Write: address and data offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        logic ta, tw;
        ta = 0;
        tw = 0;
        b_q.push_back(r);
        awa <= a; wd <= d; awv <= 1; wv <= 1;
        while (!(ta && tw)) begin
            @(posedge clk);
            if (awv && awr) begin ta = 1; awv <= 0; end
            if (wv && wrdy) begin tw = 1; wv <= 0; end
        end
        do @(posedge clk); while (!bv);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
        exp_q.push_back({r, e});
        ara <= a; arv <= 1;
        do @(posedge clk); while (!arr);
        arv <= 0;
        do @(posedge clk); while (!rv);
    endtask

    // Command write, then a wait past the two-cycle busy window.
    task automatic cmd(input logic [5:0] op, input logic [4:0] d, input logic [4:0] s,
                       input logic [7:0] k);
        wr(OFS_INSTR, {k, 3'h0, s, 3'h0, d, 2'h0, op});
        repeat (3) @(posedge clk);
    endtask

    task automatic end_of_test;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test;
    end

    // ==========================================================
    // Main sequence.
    initial begin
        int s, sl, md, q;
        logic [15:0] p, a, np;
        logic [7:0] v, sr;
        s = $urandom(39);
        repeat (8) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        rd(8'h40, 32'h0, RESP_SLV);
        wr(OFS_STAT, 32'h0, RESP_SLV);
        for (int op = 1; op < 15; op++) begin
            sr = 8'($urandom);
            wr(OFS_STATUS_REGISTER, 32'(sr));
            cmd(6'(op), 5'h0, 5'h0, 8'h00);
            sr[7 - (op - 1) / 2] = op[0];
            rd(OFS_STATUS_REGISTER, 32'(sr));
        end
        v = 8'($urandom);
        wr(gpr(7), 32'(v));
        cmd(OP_REG_COPY, 5'd20, 5'd7, 8'h00);
        rd(gpr(20), 32'(v));
        p = 16'($urandom);
        wr(gpr(4), 32'(p[7:0]));
        wr(gpr(5), 32'(p[15:8]));
        cmd(OP_PAIR_COPY, 5'd10, 5'd4, 8'h00);
        rd(gpr(10), 32'(p[7:0]));
        rd(gpr(11), 32'(p[15:8]));
        cmd(OP_IMM_LOAD, 5'd16, 5'd0, v ^ 8'hA5);
        rd(gpr(16), 32'(v ^ 8'hA5));
        for (int i = 0; i < 15; i++) begin
            sl = SL[i];
            md = MD[i];
            p = 16'($urandom);
            v = 8'($urandom);
            q = $urandom % 64;
            if (md == 1) p[7:0] = 8'hFF;
            if (md == 2) p[7:0] = 8'h00;
            np = (md == 1) ? p + 16'h1 : (md == 2) ? p - 16'h1 : p;
            a = (md == 3) ? p + 16'(q) : (md == 2) ? np : p;
            if (sl == 0) wr(OFS_DADDR, 32'(p));
            else begin
                wr(gpr(24 + 2 * sl), 32'(p[7:0]));
                wr(gpr(25 + 2 * sl), 32'(p[15:8]));
            end
            if (i > 11) wr(gpr(3), 32'(v));
            mem_q.push_back({8'h0, a, (i > 11) ? v : 8'h00, i > 11, i < 12});
            cmd(6'(8'h13 + i), 5'd5, 5'd3, 8'(q));
            if (i < 12) rd(gpr(5), 32'(memf(a)));
            if (sl != 0) begin
                rd(gpr(24 + 2 * sl), 32'(np[7:0]));
                rd(gpr(25 + 2 * sl), 32'(np[15:8]));
            end
        end
        rd(OFS_STATUS_REGISTER, 32'(sr));
        repeat (4) @(posedge clk);
        end_of_test;
    end
endmodule // tb
